// File: sac_map.vh
// Named constants for the serial A/D converter port sequencer.
// Assumes inclusion by bare name from the design files of this block.
`ifndef SAC_MAP_VH
`define SAC_MAP_VH

// ************************************************************
// Result and output sequence
// ************************************************************
`define SAC_RES_W 8
`define SAC_IDX_W 5
`define SAC_IDX_NULL 5'h00
`define SAC_IDX_FIRST 5'h01
`define SAC_IDX_B0 5'h08
`define SAC_IDX_LSB_END 5'h0F
`define SAC_IDX_ZERO 5'h10

// ************************************************************
// Configuration word
// ************************************************************
`define SAC_CFG_W 2
`define SAC_CFG_FIRST 2'h0
`define SAC_CFG_LAST 2'h2

// ************************************************************
// Pin synchroniser layout and reset value
// ************************************************************
`define SAC_SYNC_W 3
`define SAC_SB_CS 2
`define SAC_SB_CLK 1
`define SAC_SB_DIN 0
`define SAC_SYNC_RST 3'h4

// ************************************************************
// Timing
// ************************************************************
`define SAC_CLK_NS 100
`define SAC_WAKE_NS 10000
`define SAC_WAKE_CYC ((`SAC_WAKE_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_WAKE_W 7

`endif

// File: sac_sync.v
// Two-stage synchroniser for the converter's serial port pins.
// Assumes every bit is asynchronous to mclk and needs no width beyond
// the pin group of the block.
`timescale 1ns/1ps
`include "sac_map.vh"

module sac_sync (
    // Clock and reset.
    input wire mclk,
    input wire rst_b,
    // Raw pins in, retimed levels out.
    input wire [`SAC_SYNC_W-1:0] pinIn,
    output reg [`SAC_SYNC_W-1:0] pinOut
);

    // The first stage is read by the second stage only.
    reg [`SAC_SYNC_W-1:0] stage1;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= `SAC_SYNC_RST;
            pinOut <= `SAC_SYNC_RST;
        end else begin
            stage1 <= pinIn;
            pinOut <= stage1;
        end
    end

endmodule // sac_sync

// File: sac_serial_adc.v
// Serial port and conversion sequencer of an 8-bit sampling converter.
// Assumes a host drives select, shift clock and data pins from outside
// the mclk domain, and an analog core that converts on convStart.
`timescale 1ns/1ps
`include "sac_map.vh"

module sac_serial_adc (
    // Clock and reset.
    input wire mclk,
    input wire rst_b,
    // Serial port pins from the host.
    input wire selectAndPowerdownN,
    input wire shiftClk,
    input wire serDataIn,
    // Serial data output with its enable.
    output reg serDataOut,
    output reg serDataOutEn,
    // Variant strap, sampled when select falls.
    input wire twoChannelMode,
    // Analog core side.
    input wire [`SAC_RES_W-1:0] convResult,
    output reg convPowerOn,
    output reg convStart,
    output reg convSingleEnded,
    output reg convPosSelB,
    // Status.
    output reg bitOrderSelect,
    output reg wakeShort,
    output reg resultSent
);

    // ************************************************************
    // Sequencer states
    // ************************************************************
    localparam [4:0] ST_OFF = 5'h01;
    localparam [4:0] ST_HUNT = 5'h02;
    localparam [4:0] ST_CFG = 5'h04;
    localparam [4:0] ST_NULL = 5'h08;
    localparam [4:0] ST_SEND = 5'h10;

    localparam [31:0] WAKE_CYC = `SAC_WAKE_CYC;

    // ************************************************************
    // Output bit of the sequence
    // ************************************************************
    // Index 0 is the null bit, 1..8 send B7..B0, 9..15 send B1..B7 when
    // the LSB-first repeat is on, and anything later is a zero.
    function outBit;
        input [`SAC_IDX_W-1:0] idx;
        input [`SAC_RES_W-1:0] res;
        input repeatLsb;
        reg [`SAC_IDX_W-1:0] pos;
        begin
            pos = `SAC_IDX_NULL;
            outBit = 1'b0;
            if (idx == `SAC_IDX_NULL) begin
                outBit = 1'b0;
            end else if (idx <= `SAC_IDX_B0) begin
                pos = `SAC_IDX_B0 - idx;
                outBit = res[pos[2:0]];
            end else if (repeatLsb && idx <= `SAC_IDX_LSB_END) begin
                pos = idx - `SAC_IDX_B0;
                outBit = res[pos[2:0]];
            end else begin
                outBit = 1'b0;
            end
        end
    endfunction

    // ************************************************************
    // Pin retiming and edge detection
    // ************************************************************
    wire [`SAC_SYNC_W-1:0] pinSync;
    reg clkPrev;
    reg [4:0] state;
    reg modeDual;
    reg [`SAC_CFG_W-1:0] cfgCnt;
    reg cfgSingle;
    reg cfgOdd;
    reg [`SAC_IDX_W-1:0] outIdx;
    reg [`SAC_RES_W-1:0] resHold;
    reg [`SAC_WAKE_W-1:0] wakeCnt;

    sac_sync u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .pinIn({selectAndPowerdownN, shiftClk, serDataIn}),
        .pinOut(pinSync)
    );

    wire csHigh = pinSync[`SAC_SB_CS];
    wire clkNow = pinSync[`SAC_SB_CLK];
    wire dinNow = pinSync[`SAC_SB_DIN];
    // The shift clock is sampled, so its edges become one-cycle events.
    wire sRise = clkNow & ~clkPrev;
    wire sFall = ~clkNow & clkPrev;
    wire wakeOk = wakeCnt >= WAKE_CYC[`SAC_WAKE_W-1:0];

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            clkPrev <= 1'b0;
        end else begin
            clkPrev <= clkNow;
        end
    end

    // ************************************************************
    // Wake-up time monitor
    // ************************************************************
    // The host owns the wake-up interval; this only counts it so that
    // a host that runs too fast shows up in wakeShort.
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wakeCnt <= {`SAC_WAKE_W{1'b0}};
        end else if (csHigh || state == ST_OFF) begin
            wakeCnt <= {`SAC_WAKE_W{1'b0}};
        end else if (!wakeOk) begin
            wakeCnt <= wakeCnt + 1'b1;
        end
    end

    // ************************************************************
    // Serial sequencer
    // ************************************************************
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_OFF;
            modeDual <= 1'b0;
            cfgCnt <= `SAC_CFG_FIRST;
            cfgSingle <= 1'b0;
            cfgOdd <= 1'b0;
            outIdx <= `SAC_IDX_NULL;
            resHold <= {`SAC_RES_W{1'b0}};
            serDataOut <= 1'b0;
            serDataOutEn <= 1'b0;
            convPowerOn <= 1'b0;
            convStart <= 1'b0;
            convSingleEnded <= 1'b0;
            convPosSelB <= 1'b0;
            bitOrderSelect <= 1'b0;
            wakeShort <= 1'b0;
            resultSent <= 1'b0;
        end else if (csHigh) begin
            // Select high drops the driver and powers down at once.
            state <= ST_OFF;
            serDataOut <= 1'b0;
            serDataOutEn <= 1'b0;
            convPowerOn <= 1'b0;
            convStart <= 1'b0;
            cfgCnt <= `SAC_CFG_FIRST;
            outIdx <= `SAC_IDX_NULL;
        end else begin
            convPowerOn <= 1'b1;
            convStart <= 1'b0;
            case (state)
                ST_OFF: begin
                    // Select has fallen: a new exchange begins.
                    modeDual <= twoChannelMode;
                    wakeShort <= 1'b0;
                    resultSent <= 1'b0;
                    cfgCnt <= `SAC_CFG_FIRST;
                    outIdx <= `SAC_IDX_NULL;
                    state <= ST_HUNT;
                end
                ST_HUNT: begin
                    if (sRise) begin
                        if (!modeDual) begin
                            // Fixed differential input, no word.
                            convSingleEnded <= 1'b0;
                            convPosSelB <= 1'b0;
                            bitOrderSelect <= 1'b0;
                            convStart <= 1'b1;
                            state <= ST_NULL;
                        end else if (dinNow) begin
                            // Leading zeros are skipped.
                            cfgCnt <= `SAC_CFG_FIRST;
                            state <= ST_CFG;
                        end
                    end
                end
                ST_CFG: begin
                    if (sFall && cfgCnt == `SAC_CFG_LAST) begin
                        // Falling edge that launches the order bit.
                        if (!wakeOk) begin
                            wakeShort <= 1'b1;
                        end
                    end
                    if (sRise) begin
                        case (cfgCnt)
                            `SAC_CFG_FIRST: begin
                                cfgSingle <= dinNow;
                            end
                            `SAC_CFG_LAST: begin
                                // Word complete: mux set, convert.
                                bitOrderSelect <= dinNow;
                                convSingleEnded <= cfgSingle;
                                convPosSelB <= cfgOdd;
                                convStart <= 1'b1;
                                state <= ST_NULL;
                            end
                            default: begin
                                cfgOdd <= dinNow;
                            end
                        endcase
                        cfgCnt <= cfgCnt + 1'b1;
                    end
                end
                ST_NULL: begin
                    // Fourth falling edge after the start bit on the
                    // two-channel part, first after first rise otherwise.
                    if (sFall) begin
                        if (!modeDual && !wakeOk) begin
                            wakeShort <= 1'b1;
                        end
                        resHold <= convResult;
                        serDataOutEn <= 1'b1;
                        serDataOut <= outBit(`SAC_IDX_NULL,
                            convResult, 1'b0);
                        outIdx <= `SAC_IDX_FIRST;
                        state <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    // Input is ignored here: the port is half duplex.
                    if (sFall) begin
                        serDataOut <= outBit(outIdx, resHold,
                            ~bitOrderSelect);
                        if (outIdx == `SAC_IDX_B0) begin
                            resultSent <= 1'b1;
                        end
                        if (outIdx != `SAC_IDX_ZERO) begin
                            outIdx <= outIdx + 1'b1;
                        end
                    end
                end
                default: begin
                    state <= ST_OFF;
                    serDataOutEn <= 1'b0;
                end
            endcase
        end
    end

endmodule // sac_serial_adc

// File: sac_serial_adc_asserts.sv
// Assertions on the ports of the serial converter sequencer.
// Assumes a bind onto sac_serial_adc; pins reach it through a sync lag.
`timescale 1ns/1ps
module sac_serial_adc_chk (
    // Clock, reset and serial pins.
    input wire mclk,
    input wire rst_b,
    input wire selectAndPowerdownN,
    input wire shiftClk,
    input wire serDataOut,
    input wire serDataOutEn,
    // Core side and status.
    input wire twoChannelMode,
    input wire convPowerOn,
    input wire convStart,
    input wire convSingleEnded,
    input wire convPosSelB,
    input wire bitOrderSelect,
    input wire resultSent
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Five samples cover the synchroniser and the output register.
    sequence s_selLow; !selectAndPowerdownN [*5]; endsequence
    sequence s_selHigh; selectAndPowerdownN [*5]; endsequence
    property p_pwr_on; s_selLow |-> convPowerOn; endproperty
    property p_pwr_off;
        s_selHigh |-> !convPowerOn && !serDataOutEn && !convStart;
    endproperty
    property p_launch;
        $changed(serDataOut) |-> !$past(shiftClk) && !$past(shiftClk, 2);
    endproperty
    property p_start;
        convStart |-> (convPowerOn && !serDataOutEn) ##1 !convStart;
    endproperty
    property p_null; $rose(serDataOutEn) |-> !serDataOut; endproperty
    property p_hold; s_selLow ##0 serDataOutEn |=> serDataOutEn; endproperty
    property p_fixed;
        convStart && !twoChannelMode |->
            !convSingleEnded && !convPosSelB && !bitOrderSelect;
    endproperty
    property p_sent; $rose(resultSent) |-> serDataOutEn; endproperty
    a_pwr_on: assert property (p_pwr_on) else $error("not powered");
    a_pwr_off: assert property (p_pwr_off) else $error("awake");
    a_launch: assert property (p_launch) else $error("bad edge");
    a_start: assert property (p_start) else $error("bad start");
    a_null: assert property (p_null) else $error("no null");
    a_hold: assert property (p_hold) else $error("driver lost");
    a_fixed: assert property (p_fixed) else $error("not fixed");
    a_sent: assert property (p_sent) else $error("sent idle");
endmodule // sac_serial_adc_chk

// File: sac_host_model.sv
// Behavioural host driving the converter's select, clock and data pins.
// Assumes the bench raises go for a frame and waits for busy to drop.
`timescale 1ns/1ps
module sac_host_model (
    // Frame request from the bench.
    input wire mclk,
    input wire go,
    input wire [7:0] wake,
    input wire [1:0] zeros,
    input wire [2:0] cfg,
    input wire [5:0] nClk,
    output reg busy = 1'b0,
    output reg [31:0] rx = 32'h0,
    // Serial pins; the clock stands low between frames.
    output reg csN = 1'b1,
    output reg sck = 1'b0,
    output reg din = 1'b0,
    input wire dout,
    input wire doutEn
);
    integer i;
    always @(negedge mclk) begin
        if (go) begin
            busy = 1'b1;
            csN = 1'b0;
            // A wake count under the threshold is a deliberate fault.
            repeat (wake) @(negedge mclk);
            for (i = 0; i < nClk; i = i + 1) begin
                sck = 1'b0;
                // Once the word is out the line stays driven and toggles.
                din = i < zeros ? 1'b0 : i == zeros ? 1'b1 :
                    i <= zeros + 3 ? cfg[zeros + 3 - i] : ~din;
                repeat (4) @(negedge mclk);
                sck = 1'b1;
                repeat (4) @(negedge mclk);
                rx = {rx[30:0], dout & doutEn};
            end
            sck = 1'b0;
            repeat (4) @(negedge mclk);
            busy = 1'b0;
            @(negedge mclk);
            csN = 1'b1;
            din = ~din;
        end
    end
endmodule // sac_host_model

// File: tb_top.sv
// Self-checking bench for the serial converter sequencer.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/1ps
module tb_top;
    reg mclk = 1'b0, rst_b = 1'b0, two = 1'b0, go = 1'b0;
    reg [7:0] res = 8'h00, wk = 8'h00;
    reg [1:0] zr = 2'h0;
    reg [2:0] cfg = 3'h0;
    reg [5:0] nc = 6'h00;
    wire csN, sck, din, dout, oe, pwr, se, pb, bo, ws, sent, busy, st;
    wire [31:0] rx;
    reg [31:0] rnd = 32'h0;
    integer fail_count = 0, checked = 0, j, k, starts = 0;
    sac_serial_adc dut (.mclk(mclk), .rst_b(rst_b),
        .selectAndPowerdownN(csN), .shiftClk(sck), .serDataIn(din),
        .serDataOut(dout), .serDataOutEn(oe), .twoChannelMode(two),
        .convResult(res), .convPowerOn(pwr), .convStart(st),
        .convSingleEnded(se), .convPosSelB(pb), .bitOrderSelect(bo),
        .wakeShort(ws), .resultSent(sent));
    sac_host_model host (.mclk(mclk), .go(go), .wake(wk), .zeros(zr),
        .cfg(cfg), .nClk(nc), .busy(busy), .rx(rx), .csN(csN), .sck(sck),
        .din(din), .dout(dout), .doutEn(oe));
    initial forever #50 mclk = ~mclk;
    // Conversion start pulses seen since the current frame was requested.
    always @(posedge mclk) begin
        if (go)
            starts <= 0;
        else if (st)
            starts <= starts + 1;
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: %h, expected %h", $time,
                    got, exp);
            end
        end
    endtask
    // Line bit of clock period i: null, MSB first, optional LSB repeat.
    function expBit(input integer i, input integer p, input rep,
        input [7:0] r);
        expBit = i <= p ? 1'b0 : i <= p + 8 ? r[p + 8 - i] :
            rep && i <= p + 15 ? r[i - p - 8] : 1'b0;
    endfunction
    task frame(input t, input [1:0] z, input [2:0] c, input [7:0] w,
        input [5:0] n);
        integer i, p;
        reg rep;
        begin
            {two, zr, cfg, wk, nc} = {t, z, c, w, n};
            rnd = $urandom;
            res = rnd[7:0];
            go = 1'b1;
            k = 0;
            while ((go || busy) && k < 600) begin
                @(negedge mclk);
                k = k + 1;
                if (busy)
                    go = 1'b0;
            end
            chk(k < 600, 1);
            p = t ? z + 4 : 1;
            rep = t ? ~c[0] : 1'b1;
            for (i = 0; i < n; i = i + 1)
                chk(rx[n - 1 - i], expBit(i, p, rep, res));
            chk({se, pb, bo}, t ? c : 3'h0);
            chk(ws, w < 8'h32);
            chk(sent, n > p + 8);
            chk(starts, 1);
            repeat (6) @(negedge mclk);
            chk({pwr, oe}, 2'h0);
        end
    endtask
    initial begin
        k = $urandom(71858);
        repeat (12) @(negedge mclk);
        rst_b = 1'b1;
        for (j = 0; j < 8; j = j + 1)
            frame(1'b1, j[1:0], j[2:0], 8'h78, 6'h17 + j[1:0]);
        frame(1'b0, 2'h0, 3'h7, 8'h78, 6'h14);
        frame(1'b1, 2'h3, 3'h5, 8'h06, 6'h1A);
        frame(1'b0, 2'h0, 3'h0, 8'h06, 6'h14);
        frame(1'b1, 2'h0, 3'h3, 8'h78, 6'h09);
        for (j = 0; j < 6; j = j + 1) begin
            rnd = $urandom;
            frame(rnd[0], rnd[2:1], rnd[5:3], rnd[6] ? 8'h78 : 8'h06,
                6'h1A);
        end
        final_report;
    end
    initial begin
        #3000000;
        fail_count = fail_count + 1;
        final_report;
    end
    task final_report;
        begin
            $display("%0d checks, %0d mismatches", checked, fail_count);
            if (fail_count == 0 && checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
endmodule // tb_top
bind sac_serial_adc sac_serial_adc_chk u_chk (.mclk(mclk), .rst_b(rst_b),
    .selectAndPowerdownN(selectAndPowerdownN), .shiftClk(shiftClk),
    .serDataOut(serDataOut), .serDataOutEn(serDataOutEn),
    .twoChannelMode(twoChannelMode), .convPowerOn(convPowerOn),
    .convStart(convStart), .convSingleEnded(convSingleEnded),
    .convPosSelB(convPosSelB), .bitOrderSelect(bitOrderSelect),
    .resultSent(resultSent));
